/* hw/rx_bank_cfg_defines.vh */
// Purpose: Constants for the receive bank partition configuration block.
// Assumes: Register indices as printed; byte address is not used on the plain port.
// Notes: Sizes are in bytes.
`ifndef RX_BANK_CFG_DEFINES_VH
`define RX_BANK_CFG_DEFINES_VH
`define ADDR_W 20
`define REG_PART_COUNT 20'h30906
`define REG_AGGR_WIDTH 20'h30907
`define REG_BANK_STATUS 20'h30908
`define REG_FIFO_DATA 20'h30909
`define REG_FIFO_LEVEL 20'h3090A
`define PART_COUNT_RESET 8'h00
`define AGGR_WIDTH_RESET 8'h00
`define FIELD_W 2
`define AGGR_32 2'h0
`define AGGR_64 2'h1
`define AGGR_128 2'h2
`define AGGR_RSVD 2'h3
`define BASE_DATA_BYTES 16'h0800
`define FIFO_WIDTH 32
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

/* hw/rx_buffer_bank_partition_cfg.v */
// Purpose: Per-bank width and partition configuration with derived FIFO sizes.
// Assumes: Registers are reached over a plain address and strobe port.
// Notes: A 16-word FIFO buffers words entering the receive path.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "rx_bank_cfg_defines.vh"
// Behaviour
// - Each config register holds four 2-bit fields, bank 0 in the lowest bits.
// - Width code 00 is 32-bit, 01 is 64-bit, 10 is 128-bit.
// - Partition code 00..11 gives 1, 2, 4 or 8 equal virtual FIFOs.
// - Data depth is 2K bytes scaled by width, divided by partitions; control is quarter.
module rx_buffer_bank_partition_cfg (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire [`ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [31:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [31:0] out_data_out,
  output wire [63:0] data_depth_out,
  output wire [63:0] ctrl_depth_out,
  output wire [7:0] bank_width_out,
  output wire [7:0] bank_parts_out,
  output wire config_error_out
);
  // ----------------------------------------
  // Register write decode.
  // ----------------------------------------
  reg [7:0] part_count_reg;
  reg [7:0] part_count_next;
  reg [7:0] aggr_width_reg;
  reg [7:0] aggr_width_next;
  reg config_error_reg;
  reg [31:0] rdata_next;
  wire fifo_in_ready;
  wire [`FIFO_AW:0] level;
  wire [3:0] bank_bad;
  wire [3:0] bank_is_64;
  wire [3:0] bank_is_128;
  wire low_any_64;
  wire low_same;
  wire high_any_64;
  wire high_same;
  wire any_128;
  wire all_128;
  wire parts_equal;
  wire pair_bad;
  wire config_error_next;
  // Only the low byte of a write lands; the upper bits are ignored.
  // Writes to other indices leave both registers as they are.
  always @* begin
    part_count_next = part_count_reg;
    aggr_width_next = aggr_width_reg;
    if (wr_in) begin
      if (addr_in == `REG_PART_COUNT) begin
        part_count_next = wdata_in[7:0];
      end
      if (addr_in == `REG_AGGR_WIDTH) begin
        aggr_width_next = wdata_in[7:0];
      end
    end
  end
  // ----------------------------------------
  // Configuration registers.
  // ----------------------------------------
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      part_count_reg <= `PART_COUNT_RESET;
      aggr_width_reg <= `AGGR_WIDTH_RESET;
    end else begin
      part_count_reg <= part_count_next;
      aggr_width_reg <= aggr_width_next;
    end
  end
  // ----------------------------------------
  // Per-bank size derivation.
  // ----------------------------------------
  // Sizes follow the next field values, so the flopped outputs change in the
  // same cycle as the registers they are derived from.
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_bank
      wire [1:0] wcode;
      wire [1:0] pcode;
      wire [15:0] depth;
      reg [15:0] scaled;
      reg [15:0] data_depth_reg;
      reg [15:0] ctrl_depth_reg;
      assign wcode = aggr_width_next[2*b+1:2*b];
      assign pcode = part_count_next[2*b+1:2*b];
      assign bank_is_64[b] = (wcode == `AGGR_64);
      assign bank_is_128[b] = (wcode == `AGGR_128);
      // The reserved width code is flagged on its own.
      assign bank_bad[b] = (wcode == `AGGR_RSVD);
      always @* begin
        case (wcode)
          `AGGR_64: begin
            scaled = `BASE_DATA_BYTES << 1;
          end
          `AGGR_128: begin
            scaled = `BASE_DATA_BYTES << 2;
          end
          default: begin
            scaled = `BASE_DATA_BYTES;
          end
        endcase
      end
      // A reserved width code gives no storage at all.
      assign depth = (wcode == `AGGR_RSVD) ? 16'h0000 : (scaled >> pcode);
      always @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          data_depth_reg <= `BASE_DATA_BYTES;
          ctrl_depth_reg <= `BASE_DATA_BYTES >> 2;
        end else begin
          data_depth_reg <= depth;
          ctrl_depth_reg <= depth >> 2;
        end
      end
      assign data_depth_out[16*b+15:16*b] = data_depth_reg;
      assign ctrl_depth_out[16*b+15:16*b] = ctrl_depth_reg;
      assign bank_width_out[2*b+1:2*b] = aggr_width_reg[2*b+1:2*b];
      assign bank_parts_out[2*b+1:2*b] = part_count_reg[2*b+1:2*b];
    end
  endgenerate
  // ----------------------------------------
  // Configuration checks.
  // ----------------------------------------
  // Paired banks in 64-bit mode must match in width and partition count.
  assign low_any_64 = bank_is_64[0] || bank_is_64[1];
  assign low_same = (aggr_width_next[1:0] == aggr_width_next[3:2]) &&
                    (part_count_next[1:0] == part_count_next[3:2]);
  assign high_any_64 = bank_is_64[2] || bank_is_64[3];
  assign high_same = (aggr_width_next[5:4] == aggr_width_next[7:6]) &&
                     (part_count_next[5:4] == part_count_next[7:6]);
  // In 128-bit mode all four banks must match.
  assign any_128 = |bank_is_128;
  assign all_128 = &bank_is_128;
  assign parts_equal = (part_count_next == {4{part_count_next[1:0]}});
  assign pair_bad = (low_any_64 && !low_same) || (high_any_64 && !high_same) ||
                    (any_128 && !(all_128 && parts_equal));
  assign config_error_next = pair_bad || (|bank_bad);
  // ----------------------------------------
  // Status flag.
  // ----------------------------------------
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      config_error_reg <= 1'b0;
    end else begin
      config_error_reg <= config_error_next;
    end
  end
  assign config_error_out = config_error_reg;
  // ----------------------------------------
  // Receive data buffer.
  // ----------------------------------------
  // Ready is the buffer's not-full flag; nothing else holds the fill side back.
  // Words leave in the order they came, one per pop.
  assign in_ready_out = fifo_in_ready;
  rx_stream_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(in_valid_in),
    .in_ready_out(fifo_in_ready),
    .in_data_in(in_data_in),
    .out_valid_out(out_valid_out),
    .out_ready_in(out_ready_in),
    .out_data_out(out_data_out),
    .level_out(level)
  );
  // ----------------------------------------
  // Register read port.
  // ----------------------------------------
  // Read data stand for one cycle after the strobe and are zero otherwise.
  // The data index shows the head word without popping it.
  always @* begin
    rdata_next = 32'h00000000;
    if (rd_in) begin
      case (addr_in)
        `REG_PART_COUNT: begin
          rdata_next = {24'h000000, part_count_reg};
        end
        `REG_AGGR_WIDTH: begin
          rdata_next = {24'h000000, aggr_width_reg};
        end
        `REG_BANK_STATUS: begin
          rdata_next = {31'h00000000, config_error_reg};
        end
        `REG_FIFO_DATA: begin
          rdata_next = out_data_out;
        end
        `REG_FIFO_LEVEL: begin
          rdata_next = {27'h0000000, level};
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 32'h00000000;
    end else begin
      rdata_out <= rdata_next;
    end
  end
endmodule // rx_buffer_bank_partition_cfg

/* hw/rx_stream_fifo.v */
// Purpose: Flip-flop FIFO with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Depth must be a power of two.
`timescale 1ns/10ps
module rx_stream_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [AW:0] level_out
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire push;
  wire pop;
  assign level_out = wr_ptr_reg - rd_ptr_reg;
  assign in_ready_out = (level_out != DEPTH[AW:0]);
  assign out_valid_out = (level_out != {(AW+1){1'b0}});
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];
  always @(posedge sys_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // rx_stream_fifo

/* verification/fabric_reader.sv */
// Purpose: Fabric reader model for the receive FIFO.
// Assumes: Pops on valid and ready at the rising edge.
// Notes: Stall holds ready low; slow pops every other cycle.
`timescale 1ns/10ps
module fabric_reader (
  input wire sys_clk_in,
  input wire stall_in,
  input wire slow_in,
  input wire valid_in,
  input wire [31:0] data_in,
  output reg ready_out
);
  logic [31:0] got [0:31];
  int n = 0;
  initial ready_out = 1'b0;
  always @(posedge sys_clk_in) begin
    ready_out <= !stall_in && !(slow_in && ready_out);
    if (valid_in && ready_out) begin
      got[n] <= data_in;
      n <= n + 1;
    end
  end
endmodule // fabric_reader

/* verification/rx_cfg_properties.sv */
// Purpose: Checker for the bank configuration block.
// Assumes: One clock, reset active low.
// Notes: Bound to the top module.
`timescale 1ns/10ps
`include "rx_bank_cfg_defines.vh"
module rx_cfg_checker (
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire [`ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire [63:0] data_depth_out,
  input wire [63:0] ctrl_depth_out,
  input wire [7:0] bank_width_out,
  input wire [7:0] bank_parts_out,
  input wire config_error_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_wr_w;
    wr_in && addr_in == `REG_AGGR_WIDTH |=> bank_width_out == $past(wdata_in[7:0]);
  endproperty
  a_wr_w: assert property (p_wr_w) else $error("width field wrong");
  property p_wr_p;
    wr_in && addr_in == `REG_PART_COUNT |=> bank_parts_out == $past(wdata_in[7:0]);
  endproperty
  a_wr_p: assert property (p_wr_p) else $error("partition field wrong");
  property p_rd_p;
    rd_in && addr_in == `REG_PART_COUNT |=> rdata_out == {24'h000000, $past(bank_parts_out)};
  endproperty
  a_rd_p: assert property (p_rd_p) else $error("read data wrong");
  property p_depth;
    bank_width_out[7:6] != 2'h3 |->
      data_depth_out[63:48] == (16'h0800 << bank_width_out[7:6]) >> bank_parts_out[7:6];
  endproperty
  a_depth: assert property (p_depth) else $error("data depth wrong");
  property p_ctrl;
    ctrl_depth_out[15:0] == data_depth_out[15:0] >> 2;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control depth wrong");
  property p_rsvd;
    bank_width_out[1:0] == 2'h3 |-> config_error_out && data_depth_out[15:0] == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code not flagged");
  c_128: cover property (bank_width_out == 8'hAA);
  c_eight: cover property (bank_parts_out == 8'hFF);
  c_rd: cover property (rd_in && addr_in == `REG_PART_COUNT);
endmodule // rx_cfg_checker
bind rx_buffer_bank_partition_cfg rx_cfg_checker rx_cfg_checker_i (.sys_clk_in, .arst_n_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .data_depth_out, .ctrl_depth_out,
  .bank_width_out, .bank_parts_out, .config_error_out);

/* verification/testbench.sv */
// Purpose: Self-checking bench for the bank configuration block.
// Assumes: 40 MHz clock, reset held 10 cycles.
// Notes: Registers, depths and FIFO are checked.
`timescale 1ns/10ps
`include "rx_bank_cfg_defines.vh"
module testbench;
  logic sys_clk_in, arst_n_in, wr_in, rd_in, in_valid_in, stall, slow;
  logic [19:0] addr_in;
  logic [31:0] wdata_in, in_data_in, rv;
  wire [31:0] rdata_out, out_data_out;
  wire [63:0] data_depth_out, ctrl_depth_out;
  wire [7:0] bank_width_out, bank_parts_out;
  wire in_ready_out, out_valid_out, out_ready_in, config_error_out;
  int num_errors = 0;
  int cmp_count = 0;
  rx_buffer_bank_partition_cfg rx_buffer_bank_partition_cfg_i (.sys_clk_in, .arst_n_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .in_valid_in, .in_ready_out, .in_data_in,
    .out_valid_out, .out_ready_in, .out_data_out, .data_depth_out, .ctrl_depth_out,
    .bank_width_out, .bank_parts_out, .config_error_out);
  fabric_reader fabric_reader_i (.sys_clk_in, .stall_in(stall), .slow_in(slow),
    .valid_in(out_valid_out), .data_in(out_data_out), .ready_out(out_ready_in));
  task chk(string name, logic [63:0] exp, logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wr(logic [19:0] a, logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task rd(logic [19:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask
  task give_verdict;
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task t_reset;
    chk("depth", {4{16'h0800}}, data_depth_out);
    chk("ctrl", {4{16'h0200}}, ctrl_depth_out);
    rd(20'h30900);
    chk("unmapped", 64'h0, rv);
  endtask
  task t_modes;
    logic [15:0] d;
    for (int w = 0; w < 3; w++) for (int p = 0; p < 4; p++) begin
      wr(`REG_AGGR_WIDTH, {4{w[1:0]}});
      wr(`REG_PART_COUNT, {4{p[1:0]}});
      d = (16'h0800 << w) >> p;
      chk("depth", {4{d}}, data_depth_out);
      chk("ctrl", {4{d >> 2}}, ctrl_depth_out);
      rd(`REG_AGGR_WIDTH);
      chk("width reg", {4{w[1:0]}}, rv);
      chk("legal", 64'h0, config_error_out);
    end
  endtask
  task t_fields;
    wr(`REG_AGGR_WIDTH, 32'h0);
    wr(`REG_PART_COUNT, 32'hE4);
    chk("parts", 64'hE4, bank_parts_out);
    chk("depth", {16'h0100, 16'h0200, 16'h0400, 16'h0800}, data_depth_out);
  endtask
  task t_errors;
    wr(`REG_PART_COUNT, 32'h00);
    wr(`REG_AGGR_WIDTH, 32'h05);
    chk("error", 64'h0, config_error_out);
    chk("depth", {16'h0800, 16'h0800, 16'h1000, 16'h1000}, data_depth_out);
    wr(`REG_AGGR_WIDTH, 32'h04);
    chk("error", 64'h1, config_error_out);
    rd(`REG_BANK_STATUS);
    chk("status", 64'h1, rv);
    wr(`REG_AGGR_WIDTH, 32'h03);
    chk("error", 64'h1, config_error_out);
    chk("depth", {16'h0800, 16'h0800, 16'h0800, 16'h0000}, data_depth_out);
    wr(`REG_AGGR_WIDTH, 32'h00);
    chk("error", 64'h0, config_error_out);
  endtask
  task t_fifo;
    for (int i = 0; i < 17; i++) begin
      @(posedge sys_clk_in);
      in_valid_in <= 1'b1;
      in_data_in <= 32'h00000A00 + i;
    end
    #1 chk("ready full", 64'h0, in_ready_out);
    @(posedge sys_clk_in);
    in_valid_in <= 1'b0;
    rd(`REG_FIFO_LEVEL);
    chk("level", 64'h10, rv);
    stall <= 1'b0;
    slow <= 1'b1;
    repeat (40) @(posedge sys_clk_in);
    #1 chk("pops", 64'h10, fabric_reader_i.n);
    for (int i = 0; i < 16; i++) chk("word", 32'h00000A00 + i, fabric_reader_i.got[i]);
    chk("empty", 64'h0, out_valid_out);
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #200000 num_errors++;
    give_verdict;
  end
  initial begin
    {arst_n_in, wr_in, rd_in, in_valid_in, slow, addr_in, wdata_in, in_data_in} = '0;
    stall = 1'b1;
    repeat (10) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    t_reset;
    t_modes;
    t_fields;
    t_errors;
    t_fifo;
    give_verdict;
  end
endmodule // testbench
